// >>> verilog/ptb_timebase.sv
// pwm time base: duty comparator, four interrupt sources, clock selection
// assumes apb master on pclk, fast_tick one-cycle enables from the fast osc
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
module ptb_timebase (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        fast_tick,
	input  wire logic        ext_clk_pin,
	input  wire logic        sleep_req,
	output logic             pwm_out,
	output logic             period_evt,
	output logic             rise_evt,
	output logic             fall_evt,
	output logic             fast_osc_keep,
	output logic             core_clk_run,
	output logic             irq
);
	import ptb_pkg::*;

	// ==========================================================
	// register state
	logic        en_q, en_d;
	logic        ld_q, ld_d;
	ptb_csel_t   cs_q, cs_d;
	logic [15:0] duty_q, duty_d;
	logic [15:0] dbuf_q, dbuf_d;
	logic [15:0] phase_q, phase_d;
	logic [15:0] period_q, period_d;
	logic [3:0]  flag_q, flag_d;
	logic [3:0]  ien_q, ien_d;
	logic        sum_q, sum_d;
	logic        sumen_q, sumen_d;
	logic        peripheral_irq_enable_q, peripheral_irq_enable_d;
	logic        gie_q, gie_d;
	logic [3:0]  est_q, est_d;
	logic [3:0]  emask_q, emask_d;
	logic [31:0] rdata_q, rdata_d;

	// time base state
	logic [15:0] cnt_q, cnt_d;
	logic        pwm_q, pwm_d;
	logic [2:0]  evt_q, evt_d;
	logic        ext_s1_q, ext_s2_q, ext_s3_q;
	logic        run_q;

	// bus decode, tick, comparator matches and events
	logic        wr, rd, setup;
	logic        mapped;
	logic        tick;
	logic        m_per, m_ph, m_dc, m_ovf;
	logic [3:0]  ev;
	logic [3:0]  sw_set;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// ==========================================================
	// apb slave: zero wait states, read data latched in setup
	assign setup   = psel & ~penable;
	assign wr      = psel & penable & pwrite;
	assign rd      = psel & penable & ~pwrite;
	assign mapped  = (paddr[1:0] == 2'h0) && (paddr <= OFS_EVT_MASK);
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata  = rdata_q;

	// ==========================================================
	// clock source selection and sleep handling
	// external pin: two flops, then a third for the edge detect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
			run_q    <= 1'b0;
		end else begin
			ext_s1_q <= ext_clk_pin;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			run_q    <= ~sleep_req; // cpu and peripheral clocks stop in sleep
		end
	end

	// tick is the time base enable; only the fast source survives sleep
	always_comb begin
		unique case (cs_q)
			PTB_CS_SYS:  tick = ~sleep_req;
			PTB_CS_FAST: tick = fast_tick;
			PTB_CS_EXT:  tick = ext_s2_q & ~ext_s3_q & ~sleep_req;
			PTB_CS_NONE: tick = 1'b0;
		endcase
		tick = tick & en_q;
	end

	// the fast osc is held on whenever selected, enabled or not
	// costs power while the module is off; software should pick another source
	assign fast_osc_keep = (cs_q == PTB_CS_FAST);
	assign core_clk_run  = run_q;

	// ==========================================================
	// comparators; a duty past the period never matches while the count stays within the period
	assign m_per = tick && (cnt_q == period_q);
	assign m_ph  = tick && (cnt_q == phase_q);
	assign m_dc  = tick && (cnt_q == dbuf_q);
	// overflow only arises once the period is set below the running count
	assign m_ovf = tick && (cnt_q == 16'hffff) && !(cnt_q == period_q);
	always_comb begin
		ev           = RST_NIB;
		ev[EV_OVF]   = m_ovf;
		ev[EV_PHASE] = m_ph;
		ev[EV_DUTY]  = m_dc;
		ev[EV_PERIOD]= m_per;
	end

	// counter, output latch and buffered duty
	always_comb begin
		cnt_d  = cnt_q;
		pwm_d  = pwm_q;
		dbuf_d = dbuf_q;
		evt_d  = {m_dc, m_ph, m_per};
		if (!en_q) begin
			cnt_d = RST_WORD16;
			pwm_d = 1'b0;
		end else if (tick) begin
			cnt_d = m_per ? RST_WORD16 : cnt_q + 16'h0001;
			// fall wins over rise so equal duty and phase stays low
			if (m_dc)
				pwm_d = 1'b0;
			else if (m_ph)
				pwm_d = 1'b1;
		end
		if (m_per && ld_q)
			dbuf_d = duty_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q  <= RST_WORD16;
			pwm_q  <= 1'b0;
			dbuf_q <= RST_WORD16;
			evt_q  <= 3'h0;
		end else begin
			cnt_q  <= cnt_d;
			pwm_q  <= pwm_d;
			dbuf_q <= dbuf_d;
			evt_q  <= evt_d;
		end
	end

	assign pwm_out    = pwm_q;
	assign period_evt = evt_q[0];
	assign rise_evt   = evt_q[1];
	assign fall_evt   = evt_q[2];

	// ==========================================================
	// registers, flags and read data
	always_comb begin
		en_d     = en_q;
		ld_d     = ld_q;
		cs_d     = cs_q;
		duty_d   = duty_q;
		phase_d  = phase_q;
		period_d = period_q;
		flag_d   = flag_q;
		ien_d    = ien_q;
		sum_d    = sum_q;
		sumen_d  = sumen_q;
		peripheral_irq_enable_d   = peripheral_irq_enable_q;
		gie_d    = gie_q;
		est_d    = est_q;
		emask_d  = emask_q;
		rdata_d  = rdata_q;
		sw_set   = RST_NIB;
		// pending load ends at the period event that consumes it
		if (m_per)
			ld_d = 1'b0;
		if (wr) begin
			if (hit(paddr, OFS_CTRL)) begin
				en_d = pwdata[CTRL_EN_BIT];
				ld_d = ld_d | pwdata[CTRL_LD_BIT];
				cs_d = ptb_csel_t'(pwdata[CTRL_CS_LSB +: 2]);
			end
			if (hit(paddr, OFS_DUTY_LO))
				duty_d[7:0] = pwdata[7:0];
			if (hit(paddr, OFS_DUTY_HI))
				duty_d[15:8] = pwdata[7:0];
			if (hit(paddr, OFS_PHASE))
				phase_d = pwdata[15:0];
			if (hit(paddr, OFS_PERIOD))
				period_d = pwdata[15:0];
			if (hit(paddr, OFS_IRQ_CTRL)) begin
				sw_set = pwdata[3:0] & ~flag_q;
				flag_d = pwdata[3:0]; // software may set or clear
				ien_d  = pwdata[IRQ_EN_LSB +: 4];
			end
			if (hit(paddr, OFS_PERIPH)) begin
				sum_d   = pwdata[PER_SUM_FLAG];
				sumen_d = pwdata[PER_SUM_EN];
				peripheral_irq_enable_d  = pwdata[PER_PERIPHERAL_IRQ_ENABLE];
				gie_d   = pwdata[PER_GIE];
			end
			if (hit(paddr, OFS_EVT_MASK))
				emask_d = pwdata[3:0];
		end
		// clear only the bits this read returned, so an event in setup is kept
		if (rd && hit(paddr, OFS_EVT_STAT))
			est_d = est_q & ~rdata_q[3:0];
		// disabling drops the source flags but keeps the summary
		if (wr && hit(paddr, OFS_CTRL) && !pwdata[CTRL_EN_BIT])
			flag_d = RST_NIB;
		// events set after every clear so a same-cycle event is kept
		flag_d = flag_d | ev;
		est_d  = est_d | ev;
		if (((ev | sw_set) != RST_NIB) && (ien_d != RST_NIB))
			sum_d = 1'b1;
		// read data latched in setup so prdata comes from a flop
		if (setup) begin
			unique case (1'b1)
				hit(paddr, OFS_CTRL):     rdata_d = {28'h0, cs_q, ld_q, en_q};
				hit(paddr, OFS_DUTY_LO):  rdata_d = {24'h0, duty_q[7:0]};
				hit(paddr, OFS_DUTY_HI):  rdata_d = {24'h0, duty_q[15:8]};
				hit(paddr, OFS_PHASE):    rdata_d = {16'h0, phase_q};
				hit(paddr, OFS_PERIOD):   rdata_d = {16'h0, period_q};
				hit(paddr, OFS_IRQ_CTRL): rdata_d = {24'h0, ien_q, flag_q};
				hit(paddr, OFS_PERIPH):   rdata_d = {28'h0, gie_q, peripheral_irq_enable_q, sumen_q, sum_q};
				hit(paddr, OFS_COUNTER):  rdata_d = {16'h0, cnt_q};
				hit(paddr, OFS_EVT_STAT): rdata_d = {28'h0, est_q};
				hit(paddr, OFS_EVT_MASK): rdata_d = {28'h0, emask_q};
				default:                  rdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q     <= 1'b0;
			ld_q     <= 1'b0;
			cs_q     <= PTB_CS_SYS;
			duty_q   <= RST_WORD16;
			phase_q  <= RST_WORD16;
			period_q <= RST_WORD16;
			flag_q   <= RST_NIB;
			ien_q    <= RST_NIB;
			sum_q    <= 1'b0;
			sumen_q  <= 1'b0;
			peripheral_irq_enable_q   <= 1'b0;
			gie_q    <= 1'b0;
			est_q    <= RST_NIB;
			emask_q  <= RST_NIB;
			rdata_q  <= 32'h0;
		end else begin
			en_q     <= en_d;
			ld_q     <= ld_d;
			cs_q     <= cs_d;
			duty_q   <= duty_d;
			phase_q  <= phase_d;
			period_q <= period_d;
			flag_q   <= flag_d;
			ien_q    <= ien_d;
			sum_q    <= sum_d;
			sumen_q  <= sumen_d;
			peripheral_irq_enable_q   <= peripheral_irq_enable_d;
			gie_q    <= gie_d;
			est_q    <= est_d;
			emask_q  <= emask_d;
			rdata_q  <= rdata_d;
		end
	end

	// ==========================================================
	// interrupt output: the documented cpu path or the masked event status
	// summary is left to software, which clears source flags first
	// the masked status path is a second, simpler way to the same pin
	assign irq = (sum_q & sumen_q & peripheral_irq_enable_q & gie_q) | |(est_q & emask_q);

	// ==========================================================
	// checks
	// assertions watch the comparators, flags, irq path and clock selection; covers mark what the bench reaches
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_fall_on_match: assert property (m_dc |=> fall_evt && !pwm_out)
		else $error("duty match gave no falling edge");
	a_duty_flag_set: assert property (m_dc |=> flag_q[EV_DUTY])
		else $error("duty match flag not set");
	a_load_at_period: assert property (m_per && ld_q && !wr |=> dbuf_q == $past(duty_q))
		else $error("duty buffer not loaded at period");
	a_hold_no_load: assert property (!(m_per && ld_q) |=> dbuf_q == $past(dbuf_q))
		else $error("duty buffer changed outside load");
	a_zero_duty: assert property (m_dc && m_ph |=> !pwm_out ##1 !pwm_out || m_ph)
		else $error("output asserted at equal duty and phase");
	a_no_fall_beyond: assert property (dbuf_q > period_q && cnt_q <= period_q |=> !fall_evt)
		else $error("falling edge with duty past period");
	a_flag_indep: assert property (m_per && !wr |=> flag_q[EV_PERIOD])
		else $error("period flag not set");
	a_summary_gate: assert property ($rose(sum_q) && !$past(wr) |-> $past(ien_q) != RST_NIB)
		else $error("summary set with no source enabled");
	a_cpu_irq_path: assert property (sum_q && sumen_q && peripheral_irq_enable_q && gie_q |-> irq)
		else $error("cpu interrupt missing");
	a_disable_clears: assert property ($fell(en_q) && !$past(tick) |-> flag_q == RST_NIB && sum_q == $past(sum_q))
		else $error("disable did not clear source flags");
	a_fast_keep: assert property (cs_q == PTB_CS_FAST |-> fast_osc_keep)
		else $error("fast osc released while selected");
	a_sleep_stop: assert property (sleep_req && cs_q != PTB_CS_FAST |-> !tick)
		else $error("time base ticked in sleep");

	c_pwm_rise:   cover property (m_ph ##1 pwm_out);
	c_duty_load:  cover property (m_per && ld_q);
	c_irq_raised: cover property ($rose(irq));
	c_fast_sleep: cover property (sleep_req && tick);
	c_overflow:   cover property (m_ovf);

endmodule // ptb_timebase

// >>> verilog/ptb_pkg.sv
// package for the pwm time base: register map, field positions, reset values
// assumes a 32-bit apb register bus with one aligned word per register
package ptb_pkg;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_DUTY_LO  = 8'h04;
	localparam logic [7:0] OFS_DUTY_HI  = 8'h08;
	localparam logic [7:0] OFS_PHASE    = 8'h0c;
	localparam logic [7:0] OFS_PERIOD   = 8'h10;
	localparam logic [7:0] OFS_IRQ_CTRL = 8'h14;
	localparam logic [7:0] OFS_PERIPH   = 8'h18;
	localparam logic [7:0] OFS_COUNTER  = 8'h1c;
	localparam logic [7:0] OFS_EVT_STAT = 8'h20;
	localparam logic [7:0] OFS_EVT_MASK = 8'h24;

	// ==========================================================
	// module_control fields
	localparam int CTRL_EN_BIT  = 0;
	localparam int CTRL_LD_BIT  = 1;
	localparam int CTRL_CS_LSB  = 2;

	// timebase_irq_ctrl: flags in [3:0], enables in [7:4]
	localparam int IRQ_EN_LSB   = 4;
	localparam int EV_OVF       = 0;
	localparam int EV_PHASE     = 1;
	localparam int EV_DUTY      = 2;
	localparam int EV_PERIOD    = 3;

	// peripheral flag / enable bits, gathered in one word
	localparam int PER_SUM_FLAG = 0;
	localparam int PER_SUM_EN   = 1;
	localparam int PER_PERIPHERAL_IRQ_ENABLE     = 2;
	localparam int PER_GIE      = 3;

	// ==========================================================
	// reset values
	localparam logic [15:0] RST_WORD16 = 16'h0000;
	localparam logic [3:0]  RST_NIB    = 4'h0;

	// clock_select encodings
	typedef enum logic [1:0] {
		PTB_CS_SYS  = 2'h0,
		PTB_CS_FAST = 2'h1,
		PTB_CS_EXT  = 2'h2,
		PTB_CS_NONE = 2'h3
	} ptb_csel_t;

endpackage

// >>> tb/tb_top.sv
// testbench for the pwm time base: apb driver, reference counts, flag checks
// assumes zero wait state apb, one system clock, flags in [3:0] of stat words
`timescale 1ns/1ps
module tb_top;
	import ptb_pkg::*;
	// ==========================================================
	// signals
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, c1;
	logic        pready, pslverr, serr, fast_tick = 0, ext_clk_pin = 0, sleep_req = 0;
	logic        pwm_out, period_evt, rise_evt, fall_evt, fast_osc_keep, core_clk_run, irq;
	logic [2:0]  ediv = 0;
	int          num_errors = 0, checked = 0;
	int          per, ph, du, hi, nf, nr, k;

	ptb_timebase dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fast_tick(fast_tick), .ext_clk_pin(ext_clk_pin),
		.sleep_req(sleep_req), .pwm_out(pwm_out), .period_evt(period_evt),
		.rise_evt(rise_evt), .fall_evt(fall_evt), .fast_osc_keep(fast_osc_keep),
		.core_clk_run(core_clk_run), .irq(irq));

	always #5 pclk = ~pclk;
	// fast osc stand-in is random; ext pin stays 4 cycles per level for the sync
	// the stand-in is its own source, never the system clock pll
	always @(posedge pclk) begin
		fast_tick <= ($urandom % 3) != 0;
		ediv <= ediv + 3'h1;
		ext_clk_pin <= ediv[2];
	end

	// ==========================================================
	// checking and closing
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask

	task results;
		$display("checked %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========================================================
	// apb master: request holds until pready is seen high
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (n >= 40) begin
			chk("pready", 0, 1);
			results;
		end
		rd = prdata;
		serr = pslverr;
		psel <= 0; penable <= 0;
	endtask

	task wr(input logic [7:0] a, input int d);
		xfer(1, a, 32'(d));
	endtask

	task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		xfer(0, a, 0);
		chk(nm, rd, exp);
	endtask

	// duty written as two bytes, then control word
	task cfg(input int d, input int ctl);
		wr(OFS_DUTY_LO, d & 255);
		wr(OFS_DUTY_HI, (d >> 8) & 255);
		wr(OFS_CTRL, ctl);
	endtask

	// reference: per period, one rise, one fall if duty reachable, high = duty - phase
	task pwm_chk(input int d);
		int p1, np;
		p1 = per + 1;
		repeat (2 * p1 + 4) @(posedge pclk);
		wr(OFS_IRQ_CTRL, 0);
		hi = 0; nf = 0; nr = 0;
		np = 0;
		repeat (3 * p1) begin
			@(posedge pclk);
			hi += (pwm_out === 1'b1);
			nf += (fall_evt === 1'b1);
			nr += (rise_evt === 1'b1);
			np += (period_evt === 1'b1);
		end
		chk("high", hi, d > per ? 3 * p1 : 3 * (d - ph));
		chk("falls", nf, d > per ? 0 : 3);
		chk("rises", nr, 3);
		chk("periods", np, 3);
		rdc("flags", OFS_IRQ_CTRL, {28'h0, 1'b1, d <= per, 2'b10});
	endtask

	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(9609));
		repeat (6) @(posedge pclk);
		presetn <= 1;
		rdc("ctrl", OFS_CTRL, 0);
		rdc("irqc", OFS_IRQ_CTRL, 0);
		rdc("peri", OFS_PERIPH, 0);
		xfer(0, 8'h28, 0);
		chk("slverr", serr, 1);
		chk("rd_unmapped", rd, 0);
		xfer(1, 8'h06, 32'hff);
		chk("slverr_mis", serr, 1);
		// random settings; second is zero percent, third has a period of 256 to 405
		for (k = 0; k < 3; k++) begin
			per = (k == 2) ? 256 + $urandom % 150 : 3 + $urandom % 14;
			ph = $urandom % (per + 1);
			du = (k == 1) ? ph : ph + $urandom % (per - ph + 1);
			// restart the count, or a shorter period would be overshot to the wrap
			wr(OFS_CTRL, 0);
			wr(OFS_PERIOD, per);
			wr(OFS_PHASE, ph);
			cfg(du, 3);
			pwm_chk(du);
		end
		du = per + 1 + $urandom % 50;
		cfg(du, 3);
		pwm_chk(du);
		// new duty without a load request must not take effect
		c1 = du;
		du = ph;
		cfg(du, 1);
		pwm_chk(c1);
		cfg(du, 3);
		pwm_chk(du);
		// interrupts: flags without enables, then the summary chain
		wr(OFS_PERIPH, 0);
		repeat (2 * per + 4) @(posedge pclk);
		rdc("sum_noen", OFS_PERIPH, 0);
		rdc("flag_noen", OFS_IRQ_CTRL, 32'he);
		wr(OFS_IRQ_CTRL, 32'h80);
		wr(OFS_PERIPH, 32'he);
		repeat (per + 4) @(posedge pclk);
		chk("irq_on", irq, 1);
		wr(OFS_PERIPH, 32'h7);
		@(posedge pclk);
		chk("irq_nogie", irq, 0);
		// second write: an event landing on the first one wins over its clear
		wr(OFS_CTRL, 0);
		wr(OFS_CTRL, 0);
		rdc("dis_flags", OFS_IRQ_CTRL, 32'h80);
		rdc("dis_sum", OFS_PERIPH, 32'h7);
		// source flags cleared before the summary flag
		wr(OFS_IRQ_CTRL, 32'h80);
		wr(OFS_PERIPH, 32'he);
		@(posedge pclk);
		chk("irq_clr", irq, 0);
		wr(OFS_IRQ_CTRL, 32'h88);
		@(posedge pclk);
		chk("irq_sw", irq, 1);
		wr(OFS_IRQ_CTRL, 0);
		wr(OFS_PERIPH, 0);
		// sticky event status, masked into the irq, cleared by read
		wr(OFS_EVT_MASK, 32'h8);
		@(posedge pclk);
		chk("irq_stat", irq, 1);
		rdc("stat", OFS_EVT_STAT, 32'he);
		@(posedge pclk);
		chk("irq_stat_clr", irq, 0);
		rdc("stat_clr", OFS_EVT_STAT, 0);
		wr(OFS_EVT_MASK, 0);
		// clock sources with and without sleep
		wr(OFS_PERIOD, 32'hffff);
		for (k = 0; k < 8; k++) begin
			sleep_req <= k >= 4;
			wr(OFS_CTRL, 1 + (k % 4) * 4);
			xfer(0, OFS_COUNTER, 0);
			c1 = rd;
			repeat (30) @(posedge pclk);
			xfer(0, OFS_COUNTER, 0);
			chk("moved", rd != c1, k % 4 == 1 || k < 3);
			chk("osc_keep", fast_osc_keep, k % 4 == 1);
			chk("core_run", core_clk_run, k < 4);
		end
		// overflow: period below the running count, so the counter wraps
		sleep_req <= 0;
		wr(OFS_EVT_MASK, 32'h1);
		wr(OFS_PERIOD, 1);
		wr(OFS_CTRL, 1);
		k = 0;
		while (irq !== 1'b1 && k < 70000) begin
			@(posedge pclk);
			k++;
		end
		chk("ovf_irq", irq, 1);
		if (k >= 70000)
			results;
		xfer(0, OFS_IRQ_CTRL, 0);
		chk("ovf_flag", rd[0], 1);
		wr(OFS_EVT_MASK, 0);
		wr(OFS_CTRL, 32'h4);
		@(posedge pclk);
		chk("keep_dis", fast_osc_keep, 1);
		results;
	end
endmodule // tb_top
